// ### src/bpw_watchdog.v
// Watchdog timer with I/O port registers and a boot-time arming option
`timescale 1ns/1ns
`include "bpw_defs.vh"
module bpw_watchdog #(
  parameter integer TICK_DIV = `BPW_CLK_HZ
)(
  input  wire        CLK,
  input  wire        RST,
  input  wire        CE,
  input  wire [15:0] IO_ADDR,
  input  wire [7:0]  IO_WDATA,
  input  wire        IO_WR,
  input  wire        IO_RD,
  input  wire [1:0]  BOOT_SEL,
  output reg  [7:0]  IO_RDATA,
  output reg         CPU_RESET,
  output reg         WDT_RUNNING
);
  reg  [7:0]  unit_reg;
  reg  [7:0]  count_reg;
  reg  [15:0] limit_reg;
  reg  [15:0] elapsed_reg;
  reg  [5:0]  sec_in_min_reg;
  reg  [31:0] tick_div_reg;
  reg  [15:0] pulse_reg;
  reg  [2:0]  state_reg;
  reg  [2:0]  state_next;
  reg         boot_done_reg;
  wire        sec_tick;
  wire        unit_tick;
  wire        wr_unit;
  wire        wr_count;
  wire        in_secs;
  wire        boot_arm;
  wire        svc_wr;
  wire        min_wrap;
  wire        run_next;

  // Port address match used by both read and write decoding
  function hit;
    input [15:0] addr;
    input [15:0] port;
    begin
      hit = (addr == port);
    end
  endfunction

  // Boot setting to initial limit in seconds
  function [15:0] boot_limit;
    input [1:0] sel;
    begin
      case (sel)
        `BPW_BOOT_3S:
        begin
          boot_limit = `BPW_VAL_3S;
        end
        `BPW_BOOT_30S:
        begin
          boot_limit = `BPW_VAL_30S;
        end
        `BPW_BOOT_300S:
        begin
          boot_limit = `BPW_VAL_300S;
        end
        default:
        begin
          boot_limit = 16'h0000;
        end
      endcase
    end
  endfunction

  assign wr_unit   = IO_WR && hit(IO_ADDR, `BPW_ADDR_UNIT);
  assign wr_count  = IO_WR && hit(IO_ADDR, `BPW_ADDR_COUNT);
  // Count-port writes in the boot-sample cycle are ignored
  assign svc_wr    = boot_done_reg && wr_count;
  assign boot_arm  = !boot_done_reg && (BOOT_SEL != `BPW_BOOT_OFF);
  assign in_secs   = unit_reg[`BPW_UNIT_BIT];
  assign sec_tick  = (tick_div_reg == (TICK_DIV - 1));
  assign min_wrap  = (sec_in_min_reg == (`BPW_SECS_PER_MIN - 6'h01));
  // A minute tick comes on the sixtieth second
  assign unit_tick = sec_tick && (in_secs || min_wrap);
  assign run_next  = boot_arm || (state_next == `BPW_ST_RUN);

  always @*
  begin
    state_next = state_reg;
    case (state_reg)
      `BPW_ST_IDLE:
      begin
        if (svc_wr && (IO_WDATA != 8'h00))
        begin
          state_next = `BPW_ST_RUN;
        end
      end
      `BPW_ST_RUN:
      begin
        if (svc_wr && (IO_WDATA == 8'h00))
        begin
          state_next = `BPW_ST_IDLE;
        end
        else if (!svc_wr && unit_tick && (elapsed_reg + 16'h0001 >= limit_reg))
        begin
          state_next = `BPW_ST_FIRE;
        end
      end
      `BPW_ST_FIRE:
      begin
        if (pulse_reg == 16'h0000)
        begin
          state_next = `BPW_ST_IDLE;
        end
      end
      default:
      begin
        state_next = `BPW_ST_IDLE;
      end
    endcase
  end

  // Second timebase, restarted by boot arming and by every service write
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      tick_div_reg   <= 32'h00000000;
      sec_in_min_reg <= 6'h00;
    end
    else if (CE)
    begin
      if (boot_arm || svc_wr)
      begin
        tick_div_reg   <= 32'h00000000;
        sec_in_min_reg <= 6'h00;
      end
      else if (sec_tick)
      begin
        tick_div_reg   <= 32'h00000000;
        sec_in_min_reg <= min_wrap ? 6'h00 : sec_in_min_reg + 6'h01;
      end
      else
      begin
        tick_div_reg <= tick_div_reg + 32'h00000001;
      end
    end
  end

  // Unit, count, limit and elapsed registers
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      unit_reg      <= 8'h00;
      count_reg     <= 8'h00;
      limit_reg     <= 16'h0000;
      elapsed_reg   <= 16'h0000;
      boot_done_reg <= 1'b0;
    end
    else if (CE)
    begin
      if (boot_arm)
      begin
        unit_reg <= `BPW_UNIT_SECS;
      end
      else if (wr_unit)
      begin
        unit_reg <= IO_WDATA;
      end
      // Boot arming is taken once, the first enabled cycle after reset
      if (!boot_done_reg)
      begin
        boot_done_reg <= 1'b1;
        elapsed_reg   <= 16'h0000;
        limit_reg     <= boot_limit(BOOT_SEL);
      end
      else if (wr_count)
      begin
        // Service write reloads and restarts the interval
        count_reg   <= IO_WDATA;
        limit_reg   <= {8'h00, IO_WDATA};
        elapsed_reg <= 16'h0000;
      end
      else if (state_reg == `BPW_ST_RUN && unit_tick)
      begin
        elapsed_reg <= elapsed_reg + 16'h0001;
      end
    end
  end

  // State register and reset pulse length
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      state_reg <= `BPW_ST_IDLE;
      pulse_reg <= 16'h0000;
    end
    else if (CE)
    begin
      if (boot_arm)
      begin
        state_reg <= `BPW_ST_RUN;
      end
      else
      begin
        state_reg <= state_next;
      end
      if (state_next == `BPW_ST_FIRE && state_reg != `BPW_ST_FIRE)
      begin
        pulse_reg <= `BPW_RST_PULSE_LAST;
      end
      else if (pulse_reg != 16'h0000)
      begin
        pulse_reg <= pulse_reg - 16'h0001;
      end
    end
  end

  // Registered outputs
  always @(posedge CLK or posedge RST)
  begin
    if (RST)
    begin
      IO_RDATA    <= 8'h00;
      CPU_RESET   <= 1'b0;
      WDT_RUNNING <= 1'b0;
    end
    else if (CE)
    begin
      CPU_RESET   <= (state_next == `BPW_ST_FIRE);
      WDT_RUNNING <= run_next;
      if (IO_RD && hit(IO_ADDR, `BPW_ADDR_UNIT))
      begin
        IO_RDATA <= unit_reg;
      end
      else if (IO_RD && hit(IO_ADDR, `BPW_ADDR_COUNT))
      begin
        IO_RDATA <= count_reg;
      end
      else
      begin
        IO_RDATA <= 8'h00;
      end
    end
  end
endmodule // bpw_watchdog

// ### include/bpw_defs.vh
// Constants for the boot programmable watchdog
// Function
// - A non-zero write to the timeout port starts the watchdog.
// - Software rewrites the timeout count; each write restarts the interval.
// - Interval elapsing without service asserts reset to the CPU.
// - Writing zero to the timeout port stops the watchdog entirely.
// - Unit-select bit 7 low means the count is in minutes.
// - Unit-select bit 7 high means the count is in seconds.
// - Run-time timeouts span one second up to 255 minutes.
// - Boot setting arms at power-on: disabled, 3, 30 or 300 seconds.
`ifndef BPW_DEFS_VH
`define BPW_DEFS_VH
`define BPW_ADDR_UNIT      16'h0565
`define BPW_ADDR_COUNT     16'h0566
`define BPW_UNIT_BIT       7
`define BPW_UNIT_SECS      8'h80
`define BPW_SECS_PER_MIN   6'h3c
`define BPW_BOOT_OFF       2'h0
`define BPW_BOOT_3S        2'h1
`define BPW_BOOT_30S       2'h2
`define BPW_BOOT_300S      2'h3
`define BPW_VAL_3S         16'h0003
`define BPW_VAL_30S        16'h001e
`define BPW_VAL_300S       16'h012c
`define BPW_CLK_HZ         100000000
`define BPW_RST_PULSE_NS   1000
`define BPW_RST_PULSE_CYC  ((`BPW_RST_PULSE_NS * (`BPW_CLK_HZ / 1000000)) / 1000)
`define BPW_RST_PULSE_LAST 16'h0063
`define BPW_ST_IDLE        3'h1
`define BPW_ST_RUN         3'h2
`define BPW_ST_FIRE        3'h4
`endif

// ### sim/bpw_watchdog_props.sv
// Port assertions for the watchdog
`timescale 1ns/1ns
module bpw_props #(parameter integer TICK_DIV = 10)(
  input wire        CLK,
  input wire        RST,
  input wire        CE,
  input wire [15:0] IO_ADDR,
  input wire [7:0]  IO_WDATA,
  input wire        IO_WR,
  input wire        IO_RD,
  input wire [1:0]  BOOT_SEL,
  input wire [7:0]  IO_RDATA,
  input wire        CPU_RESET,
  input wire        WDT_RUNNING
);
  default clocking @(posedge CLK); endclocking
  default disable iff (RST);
  wire cw = CE && IO_WR && IO_ADDR == 16'h0566;
  sequence s_svc; cw && IO_WDATA != 8'h00 && !CPU_RESET; endsequence
  sequence s_fire; $rose(CPU_RESET); endsequence
  a_count_starts: assert property (s_svc |=> WDT_RUNNING)
    else $error("no start");
  a_zero_stops: assert property (cw && IO_WDATA == 8'h00 |=> !WDT_RUNNING)
    else $error("no stop");
  a_service_holds: assert property (s_svc |=> !CPU_RESET [*8])
    else $error("early reset");
  a_fire_after_run: assert property (s_fire |-> $past(WDT_RUNNING))
    else $error("reset while idle");
  a_pulse_width: assert property (s_fire |-> ##99 CPU_RESET ##1 !CPU_RESET)
    else $error("bad pulse");
  a_idle_quiet: assert property (!WDT_RUNNING |=> !$rose(CPU_RESET))
    else $error("stopped yet fired");
  a_unmapped_zero: assert property (CE && IO_RD && IO_ADDR != 16'h0565
    && IO_ADDR != 16'h0566 |=> IO_RDATA == 8'h00) else $error("unmapped data");
  a_count_readback: assert property (cw ##2 CE && IO_RD && IO_ADDR == 16'h0566
    |=> IO_RDATA == $past(IO_WDATA, 3)) else $error("bad readback");
endmodule // bpw_props
bind bpw_watchdog bpw_props #(.TICK_DIV(TICK_DIV)) u_props (.CLK(CLK), .RST(RST), .CE(CE),
  .IO_ADDR(IO_ADDR), .IO_WDATA(IO_WDATA), .IO_WR(IO_WR), .IO_RD(IO_RD), .BOOT_SEL(BOOT_SEL),
  .IO_RDATA(IO_RDATA), .CPU_RESET(CPU_RESET), .WDT_RUNNING(WDT_RUNNING));

// ### sim/bpw_watchdog_tb.sv
// Self-checking bench for the watchdog
`timescale 1ns/1ns
module bpw_watchdog_tb;
  reg         CLK = 1'b0;
  reg         RST = 1'b1;
  reg  [15:0] IO_ADDR = 16'h0000;
  reg  [7:0]  IO_WDATA = 8'h00;
  reg         IO_WR = 1'b0;
  reg         IO_RD = 1'b0;
  reg         CE = 1'b1;
  reg  [1:0]  BOOT_SEL = 2'h1;
  wire [7:0]  IO_RDATA;
  wire        CPU_RESET;
  wire        WDT_RUNNING;
  integer     n_fail = 0;
  integer     n_compared = 0;
  integer     n;
  integer     cyc = 0;
  bpw_watchdog #(.TICK_DIV(10)) dut (.CLK(CLK), .RST(RST), .CE(CE), .IO_ADDR(IO_ADDR),
    .IO_WDATA(IO_WDATA), .IO_WR(IO_WR), .IO_RD(IO_RD), .BOOT_SEL(BOOT_SEL), .IO_RDATA(IO_RDATA),
    .CPU_RESET(CPU_RESET), .WDT_RUNNING(WDT_RUNNING));
  initial forever #5 CLK = ~CLK;
  always @(posedge CLK)
  begin
    cyc = cyc + 1;
    if (cyc == 8000)
    begin
      n_fail = n_fail + 1;
      conclude;
    end
  end
  task chk(input string nm, input [7:0] e, input [7:0] g);
  begin
    n_compared = n_compared + 1;
    if (g !== e)
    begin
      n_fail = n_fail + 1;
      $display("mismatch %s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  task wr(input [15:0] a, input [7:0] d);
  begin
    IO_ADDR = a;
    IO_WDATA = d;
    IO_WR = 1'b1;
    @(negedge CLK);
    IO_WR = 1'b0;
    @(negedge CLK);
  end
  endtask
  task rd(input [15:0] a, input [7:0] e);
  begin
    IO_ADDR = a;
    IO_RD = 1'b1;
    @(negedge CLK);
    IO_RD = 1'b0;
    chk("rdata", e, IO_RDATA);
    @(negedge CLK);
  end
  endtask
  // Cycles until the CPU reset rises must fall in [lo, hi]
  task meas(input integer lo, input integer hi);
  begin
    n = 0;
    while (CPU_RESET !== 1'b1 && n <= hi)
    begin
      @(negedge CLK);
      n = n + 1;
    end
    chk("delay", 8'h01, {7'h00, n >= lo && n <= hi});
    repeat (110) @(negedge CLK);
  end
  endtask
  task conclude;
  begin
    $display("compared %0d failed %0d", n_compared, n_fail);
    if (n_fail == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  end
  endtask
  initial
  begin
    repeat (10) @(negedge CLK);
    RST = 1'b0;
    repeat (2) @(negedge CLK);
    rd(16'h0565, 8'h80);
    meas(15, 35);
    $display("boot test done");
    wr(16'h0565, 8'h80);
    wr(16'h0566, 8'h02);
    rd(16'h0566, 8'h02);
    meas(8, 22);
    repeat (4)
    begin
      repeat (15) @(negedge CLK);
      wr(16'h0566, 8'h02);
    end
    chk("reset", 8'h00, {7'h00, CPU_RESET});
    chk("run", 8'h01, {7'h00, WDT_RUNNING});
    wr(16'h0566, 8'h00);
    repeat (100) @(negedge CLK);
    chk("stopped", 8'h00, {7'h00, CPU_RESET | WDT_RUNNING});
    $display("seconds test done");
    wr(16'h0565, 8'h00);
    wr(16'h0566, 8'h01);
    meas(588, 602);
    rd(16'h0567, 8'h00);
    $display("minutes test done");
    BOOT_SEL = 2'h3;
    RST = 1'b1;
    repeat (10) @(negedge CLK);
    RST = 1'b0;
    repeat (2) @(negedge CLK);
    rd(16'h0566, 8'h00);
    CE = 1'b0;
    repeat (50) @(negedge CLK);
    chk("frozen", 8'h01, {7'h00, WDT_RUNNING});
    CE = 1'b1;
    meas(2985, 3005);
    $display("long boot test done");
    conclude;
  end
endmodule // bpw_watchdog_tb
